// ===== include/cecl_pkg.sv
// Shared constants, request carriers and log operations for the event counter and log block.
package cecl_pkg;
  // Function and diagnostic sub-function codes served here.
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_EVCNT = 8'h0B;
  localparam logic [7:0] FC_EVLOG = 8'h0C;
  localparam logic [15:0] SUB_ECHO = 16'h0000;
  localparam logic [15:0] SUB_RESTART = 16'h0001;
  localparam logic [15:0] SUB_LISTEN = 16'h0004;
  localparam logic [15:0] SUB_CLRCNT = 16'h000A;
  localparam logic [15:0] SUB_CLROVR = 16'h0014;
  localparam logic [15:0] DATA_CLRLOG = 16'hFF00;
  localparam logic [15:0] STATUS_BUSY = 16'hFFFF;
  localparam logic [15:0] STATUS_IDLE = 16'h0000;
  // Reply lengths in bytes.
  localparam logic [6:0] ECHO_LEN = 7'h05;
  localparam logic [6:0] EVLOG_HDR = 7'h08;
  localparam logic [6:0] LOG_HDR_BYTES = 7'h06;
  // Event log geometry and fixed event values.
  localparam int LOG_DEPTH = 64;
  localparam logic [6:0] LOG_FULL = 7'h40;
  localparam logic [7:0] EV_RESTART = 8'h00;
  localparam logic [7:0] EV_LISTEN = 8'h04;
  // Event byte field positions.
  localparam int EVB_RX = 7;
  localparam int EVB_SEND = 6;
  localparam int EVB_LISTEN = 5;
  localparam int RX_COMMERR = 1;
  localparam int RX_OVR = 4;
  localparam int RX_BCAST = 6;
  localparam int TX_EXC13 = 0;
  localparam int TX_EXC4 = 1;
  localparam int TX_EXC56 = 2;
  localparam int TX_EXC7 = 3;
  localparam int TX_WTO = 4;
  // Register map of the plain software port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_EVCNT = 4'h1;
  localparam logic [3:0] REG_MSGCNT = 4'h2;
  localparam logic [3:0] REG_OVRCNT = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int CTRL_STOPERR = 0;
  localparam int STAT_LISTEN = 0;
  localparam int STAT_OVRFLAG = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_LEN_LSB = 8;
  // A request as delivered by the framer.
  typedef struct packed {
    logic [7:0] funcCode;
    logic [15:0] subFunc;
    logic [15:0] dataWord;
    logic broadcast;
    logic commErr;
    logic charOverrun;
  } cecl_req_t;
  // Completion report of a request served by another handler.
  typedef struct packed {
    logic valid;
    logic [3:0] excCode;
    logic wrTimeout;
  } cecl_done_t;
  typedef enum logic [1:0] {LOG_NONE, LOG_PUSH, LOG_PUSH_WIPE, LOG_CLEAR_PUSH} cecl_logop_t;
endpackage

// ===== design/cecl_counter16.sv
// Sixteen-bit wrapping event counter with synchronous clear.
`timescale 1ns/1ps
`default_nettype none
module cecl_counter16 import cecl_pkg::*; (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clr, // Zero the count, wins over inc.
  input wire logic inc, // Add one.
  output logic [15:0] count // Current count.
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;

  // Clear has priority; the count rolls over instead of saturating.
  always_comb begin
    count_nxt = count_r;
    if (clr) begin
      count_nxt = 16'h0000;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // Counter state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  a_cnt_wraps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inc && !clr && count_r == 16'hFFFF) |=> count_r == 16'h0000)
    else $error("Counter did not wrap to zero.");
endmodule
`default_nettype wire

// ===== design/cecl_event_log.sv
// Newest-first event byte log of sixty-four entries.
`timescale 1ns/1ps
`default_nettype none
module cecl_event_log import cecl_pkg::*; (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire cecl_logop_t logOp, // Operation this cycle.
  input wire logic [7:0] pushByte, // Byte entered at position zero.
  input wire logic [5:0] rdIdx, // Read position, zero is newest.
  output logic [7:0] rdByte, // Entry at rdIdx.
  output logic [6:0] logLen // Number of valid entries.
);
  logic [7:0] entry_r [LOG_DEPTH];
  logic [6:0] len_r;
  logic doOp;

  assign doOp = (logOp != LOG_NONE);

  // Entry zero takes the new byte; on a plain push the others take their younger neighbour and the oldest drops off the end, otherwise they clear.
  for (genvar i = 0; i < LOG_DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        entry_r[i] <= 8'h00;
      end else if (doOp) begin
        if (i == 0) begin
          entry_r[i] <= pushByte;
        end else if (logOp == LOG_PUSH) begin
          entry_r[i] <= entry_r[(i == 0) ? 0 : i - 1];
        end else begin
          entry_r[i] <= 8'h00;
        end
      end
    end
  end

  // Entry count saturates at the depth; a clearing push leaves one entry.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= 7'h00;
    end else if (logOp == LOG_CLEAR_PUSH) begin
      len_r <= 7'h01;
    end else if (doOp && len_r != LOG_FULL) begin
      len_r <= len_r + 7'h01;
    end
  end

  assign rdByte = entry_r[rdIdx];
  assign logLen = len_r;

  a_log_newest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    doOp |=> entry_r[0] == $past(pushByte))
    else $error("Pushed byte is not the newest entry.");
  a_log_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logOp == LOG_PUSH |=> entry_r[LOG_DEPTH - 1] == $past(entry_r[LOG_DEPTH - 2]))
    else $error("Older entries did not shift along.");
  a_log_wipe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    logOp == LOG_PUSH_WIPE |=> entry_r[1] == 8'h00 && len_r == (($past(len_r) == LOG_FULL) ? LOG_FULL : $past(len_r) + 7'h01))
    else $error("Stop-on-error restart did not zero the older entries.");
endmodule
`default_nettype wire

// ===== design/cecl_core.sv
// Event counter, event log and counter-clearing diagnostic server.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cecl_core import cecl_pkg::*; (
  input wire logic sys_clk, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic reqValid, // Framer offers a request.
  output logic reqReady, // Block can take a request.
  input wire cecl_req_t req, // Request fields and receive conditions.
  output logic fwdValid, // Pulse: request is for another handler.
  input wire cecl_done_t othDone, // Completion from the other handler.
  input wire logic progBusy, // A program command is still running.
  output logic respValid, // Reply byte is valid.
  input wire logic respReady, // Framer takes the reply byte.
  output logic [7:0] respByte, // Reply byte.
  output logic respLast, // Final byte of the reply.
  output logic listenOnly, // Port is in listen-only mode.
  output logic ovrFlag, // Character overrun flag.
  output logic [15:0] ovrCount, // Character overrun message count.
  input wire logic [3:0] regAddr, // Register address.
  input wire logic [15:0] regWdata, // Register write data.
  input wire logic regWr, // Register write strobe.
  input wire logic regRd, // Register read strobe.
  output logic [15:0] regRdata // Read data, valid the cycle after regRd.
);
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_SEND, ST_WAITX, ST_FIN, ST_RESTART} cecl_state_t;

  cecl_state_t state_r;
  cecl_state_t state_nxt;
  cecl_req_t hold_r;
  logic listen_r;
  logic ovrFlag_r;
  logic success_r;
  logic [3:0] excCode_r;
  logic wrTimeout_r;
  logic [6:0] idx_r;
  logic [6:0] respLen_r;
  logic respValid_r;
  logic [7:0] respByte_r;
  logic respLast_r;
  logic [15:0] ctrl_r;
  logic [15:0] regRdata_r;
  logic take;
  logic isDiag;
  logic isRestart;
  logic isListen;
  logic isClrCnt;
  logic isClrOvr;
  logic isOwn;
  logic suppress;
  logic willReply;
  logic advance;
  logic [15:0] statusWord;
  logic [15:0] evCount;
  logic [15:0] msgCount;
  logic [6:0] logLen;
  logic [7:0] logRd;
  logic [6:0] selIdx;
  logic [5:0] logIdx;
  logic [7:0] selByte;
  logic [7:0] rxEvent;
  logic [7:0] txEvent;
  cecl_logop_t logOp;
  logic [7:0] logByte;

  // Request decode from the held request.
  assign take = reqValid && (state_r == ST_IDLE);
  assign isDiag = (hold_r.funcCode == FC_DIAG);
  assign isRestart = isDiag && (hold_r.subFunc == SUB_RESTART);
  assign isListen = isDiag && (hold_r.subFunc == SUB_LISTEN);
  assign isClrCnt = isDiag && (hold_r.subFunc == SUB_CLRCNT);
  assign isClrOvr = isDiag && (hold_r.subFunc == SUB_CLROVR);
  assign isOwn = isRestart || isListen || isClrCnt || isClrOvr || (isDiag && hold_r.subFunc == SUB_ECHO)
                 || hold_r.funcCode == FC_EVCNT || hold_r.funcCode == FC_EVLOG;
  assign suppress = listen_r && !isRestart;
  assign willReply = isOwn && !suppress && !isListen && !(isRestart && listen_r) && !hold_r.broadcast;
  assign advance = respValid_r && respReady;
  assign statusWord = progBusy ? STATUS_BUSY : STATUS_IDLE;

  // Receive and send event bytes.
  always_comb begin
    rxEvent = 8'h00;
    rxEvent[EVB_RX] = 1'b1;
    rxEvent[RX_COMMERR] = req.commErr;
    rxEvent[RX_OVR] = req.charOverrun;
    rxEvent[EVB_LISTEN] = listen_r;
    rxEvent[RX_BCAST] = req.broadcast;
    txEvent = 8'h00;
    txEvent[EVB_SEND] = 1'b1;
    txEvent[TX_EXC13] = (excCode_r >= 4'h1) && (excCode_r <= 4'h3);
    txEvent[TX_EXC4] = (excCode_r == 4'h4);
    txEvent[TX_EXC56] = (excCode_r == 4'h5) || (excCode_r == 4'h6);
    txEvent[TX_EXC7] = (excCode_r == 4'h7);
    txEvent[TX_WTO] = wrTimeout_r;
    txEvent[EVB_LISTEN] = listen_r;
  end

  // Chooses what enters the log this cycle.
  always_comb begin
    logOp = LOG_NONE;
    logByte = 8'h00;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          logOp = LOG_PUSH;
          logByte = rxEvent;
        end
      end
      ST_EXEC: begin
        if (isListen && !listen_r) begin
          logOp = LOG_PUSH;
          logByte = EV_LISTEN;
        end
      end
      ST_FIN: begin
        logOp = LOG_PUSH;
        logByte = txEvent;
      end
      ST_RESTART: begin
        if (isRestart) begin
          logByte = EV_RESTART;
          if (hold_r.dataWord == DATA_CLRLOG) begin
            logOp = LOG_CLEAR_PUSH;
          end else if (ctrl_r[CTRL_STOPERR]) begin
            logOp = LOG_PUSH_WIPE;
          end else begin
            logOp = LOG_PUSH;
          end
        end
      end
      default: begin
        logOp = LOG_NONE;
      end
    endcase
  end

  cecl_event_log u_log (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .logOp(logOp),
    .pushByte(logByte),
    .rdIdx(logIdx),
    .rdByte(logRd),
    .logLen(logLen)
  );

  // Message counter counts every request seen; restart and clear-counters zero it.
  cecl_counter16 u_msgCnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(state_r == ST_RESTART),
    .inc(take),
    .count(msgCount)
  );

  // Event counter counts successful completions except counter fetches.
  cecl_counter16 u_evCnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(state_r == ST_RESTART),
    .inc(state_r == ST_FIN && success_r && hold_r.funcCode != FC_EVCNT),
    .count(evCount)
  );

  // Overrun counter counts requests received with a character overrun.
  cecl_counter16 u_ovrCnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(state_r == ST_RESTART || (state_r == ST_EXEC && isClrOvr && !suppress)),
    .inc(take && req.charOverrun),
    .count(ovrCount)
  );

  // Reply byte at a given position.
  assign selIdx = (state_r == ST_EXEC) ? 7'h00 : idx_r + 7'h01;
  assign logIdx = selIdx[5:0] - EVLOG_HDR[5:0];
  always_comb begin
    selByte = hold_r.funcCode;
    if (hold_r.funcCode == FC_EVCNT || hold_r.funcCode == FC_EVLOG) begin
      case (selIdx)
        7'h00: selByte = hold_r.funcCode;
        7'h01: selByte = (hold_r.funcCode == FC_EVLOG) ? {1'b0, logLen + LOG_HDR_BYTES} : statusWord[15:8];
        7'h02: selByte = (hold_r.funcCode == FC_EVLOG) ? statusWord[15:8] : statusWord[7:0];
        7'h03: selByte = (hold_r.funcCode == FC_EVLOG) ? statusWord[7:0] : evCount[15:8];
        7'h04: selByte = (hold_r.funcCode == FC_EVLOG) ? evCount[15:8] : evCount[7:0];
        7'h05: selByte = evCount[7:0];
        7'h06: selByte = msgCount[15:8];
        7'h07: selByte = msgCount[7:0];
        default: selByte = logRd;
      endcase
    end else begin
      case (selIdx)
        7'h01: selByte = hold_r.subFunc[15:8];
        7'h02: selByte = hold_r.subFunc[7:0];
        7'h03: selByte = hold_r.dataWord[15:8];
        7'h04: selByte = hold_r.dataWord[7:0];
        default: selByte = hold_r.funcCode;
      endcase
    end
  end

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (suppress) begin
          state_nxt = ST_FIN;
        end else if (!isOwn) begin
          state_nxt = ST_WAITX;
        end else if (willReply) begin
          state_nxt = ST_SEND;
        end else begin
          state_nxt = ST_FIN;
        end
      end
      ST_SEND: begin
        if (advance && respLast_r) begin
          state_nxt = ST_FIN;
        end
      end
      ST_WAITX: begin
        if (othDone.valid) begin
          state_nxt = ST_FIN;
        end
      end
      ST_FIN: begin
        state_nxt = (success_r && (isRestart || isClrCnt)) ? ST_RESTART : ST_IDLE;
      end
      ST_RESTART: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and held request.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      hold_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        hold_r <= req;
      end
    end
  end

  // Completion outcome of the current request.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      success_r <= 1'b0;
      excCode_r <= 4'h0;
      wrTimeout_r <= 1'b0;
    end else if (state_r == ST_EXEC) begin
      success_r <= isOwn && !suppress;
      excCode_r <= 4'h0;
      wrTimeout_r <= 1'b0;
    end else if (state_r == ST_WAITX && othDone.valid) begin
      success_r <= (othDone.excCode == 4'h0);
      excCode_r <= othDone.excCode;
      wrTimeout_r <= othDone.wrTimeout;
    end
  end

  // Listen-only mode: entered by its sub-function, left only by a restart.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      listen_r <= 1'b0;
    end else if (state_r == ST_EXEC && isRestart) begin
      listen_r <= 1'b0;
    end else if (state_r == ST_EXEC && isListen && !listen_r) begin
      listen_r <= 1'b1;
    end
  end

  // Overrun flag: a new overrun wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovrFlag_r <= 1'b0;
    end else if (take && req.charOverrun) begin
      ovrFlag_r <= 1'b1;
    end else if (state_r == ST_EXEC && isClrOvr && !suppress) begin
      ovrFlag_r <= 1'b0;
    end
  end

  // Reply byte stream, loaded one byte ahead of the handshake.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      respValid_r <= 1'b0;
      respByte_r <= 8'h00;
      respLast_r <= 1'b0;
      idx_r <= 7'h00;
      respLen_r <= 7'h00;
    end else if (state_r == ST_EXEC && willReply && !suppress) begin
      respValid_r <= 1'b1;
      respByte_r <= selByte;
      respLast_r <= 1'b0;
      idx_r <= 7'h00;
      respLen_r <= (hold_r.funcCode == FC_EVLOG) ? EVLOG_HDR + logLen : ECHO_LEN;
    end else if (advance) begin
      respValid_r <= !respLast_r;
      respByte_r <= selByte;
      respLast_r <= (selIdx == respLen_r - 7'h01);
      idx_r <= selIdx;
    end
  end

  // Software control register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (regWr && regAddr == REG_CTRL) begin
      ctrl_r <= regWdata;
    end
  end

  // Read data for one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_r <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL: regRdata_r <= ctrl_r;
        REG_EVCNT: regRdata_r <= evCount;
        REG_MSGCNT: regRdata_r <= msgCount;
        REG_OVRCNT: regRdata_r <= ovrCount;
        REG_STAT: regRdata_r <= {1'b0, logLen, 5'h00, progBusy, ovrFlag_r, listen_r};
        default: regRdata_r <= 16'h0000;
      endcase
    end else begin
      regRdata_r <= 16'h0000;
    end
  end

  assign reqReady = (state_r == ST_IDLE);
  assign fwdValid = (state_r == ST_EXEC) && !suppress && !isOwn;
  assign respValid = respValid_r;
  assign respByte = respByte_r;
  assign respLast = respLast_r;
  assign listenOnly = listen_r;
  assign ovrFlag = ovrFlag_r;
  assign regRdata = regRdata_r;

  // Single-cycle sequences for the assertions below.
  sequence s_restart_fin;
    state_r == ST_FIN && success_r && isRestart;
  endsequence
  sequence s_clrovr_exec;
    state_r == ST_EXEC && isClrOvr && !suppress && !(reqValid && req.charOverrun);
  endsequence

  a_rx_event_log: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take |-> logOp == LOG_PUSH && logByte[EVB_RX] && logByte[3:2] == 2'b00 && !logByte[0])
    else $error("Receive event not logged on request intake.");
  a_send_event_log: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_FIN |-> logOp == LOG_PUSH && logByte[7:6] == 2'b01)
    else $error("Send event missing at request completion.");
  a_listen_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_r == ST_EXEC && suppress) |=> state_r == ST_FIN && !respValid_r)
    else $error("Listen-only mode acted on a request.");
  a_restart_zeroes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_restart_fin ##1 state_r == ST_RESTART |=> evCount == 16'h0000 && msgCount <= 16'h0001)
    else $error("Restart did not zero the event counter.");
  a_clrovr_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_clrovr_exec |=> !ovrFlag_r && ovrCount == 16'h0000)
    else $error("Overrun counter or flag not cleared.");
  a_reply_opens_fc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_r == ST_EXEC && willReply && !suppress) |=> respValid_r && respByte_r == hold_r.funcCode)
    else $error("Reply does not open with the function code.");
  a_log_bytecount: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (respValid_r && idx_r == 7'h01 && hold_r.funcCode == FC_EVLOG) |-> respByte_r == {1'b0, logLen + LOG_HDR_BYTES})
    else $error("Event log byte count is not event bytes plus six.");
endmodule
`default_nettype wire

// ===== test/cecl_far_model.sv
// Far-side model: a reply sink with random stalls and a handler for forwarded requests.
`timescale 1ns/1ps
`default_nettype none
module cecl_far_model import cecl_pkg::*; (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic fwdValid, // Request handed to this handler.
  input wire logic [3:0] excSel, // Exception code to report.
  input wire logic wtoSel, // Report a write timeout.
  output logic respReady, // Takes reply bytes, stalls at random.
  output cecl_done_t othDone // Completion report.
);
  int waitN;
  // Stalls the reply sink now and then, and answers a forwarded request after a random wait.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      respReady <= 1'b0;
      othDone <= '0;
      waitN = -1;
    end else begin
      respReady <= ($urandom_range(3) != 0);
      othDone <= {1'b0, 4'($urandom), 1'($urandom)};
      if (fwdValid) begin
        waitN = $urandom_range(6);
      end else if (waitN > 0) begin
        waitN = waitN - 1;
      end else if (waitN == 0) begin
        othDone <= {1'b1, excSel, wtoSel};
        waitN = -1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/cecl_core_bench.sv
// Self-checking bench for the event counter and log block, with a reference model of counts and log.
`timescale 1ns/1ps
`default_nettype none
module cecl_core_bench import cecl_pkg::*;;
  logic sys_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, progBusy = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic reqReady, fwdValid, respValid, respReady, respLast, listenOnly, ovrFlag, wtoSel = 1'b0;
  logic [7:0] respByte;
  logic [15:0] ovrCount, regRdata, regWdata = 16'h0000;
  logic [3:0] regAddr = 4'h0, excSel = 4'h0;
  cecl_req_t req = '0;
  cecl_done_t othDone;
  int nFail = 0, totalChecks = 0, evC = 0, msgC = 0, ovC = 0;
  bit lst = 0, stopErr = 0;
  logic [7:0] elog[$], got[$], expQ[$];
  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;
  cecl_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .fwdValid(fwdValid), .othDone(othDone), .progBusy(progBusy), .respValid(respValid), .respReady(respReady),
    .respByte(respByte), .respLast(respLast), .listenOnly(listenOnly), .ovrFlag(ovrFlag), .ovrCount(ovrCount),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  cecl_far_model far (.sys_clk(sys_clk), .rst_n(rst_n), .fwdValid(fwdValid), .excSel(excSel), .wtoSel(wtoSel),
    .respReady(respReady), .othDone(othDone));
  task automatic check(string nm, logic [15:0] e, logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      nFail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Newest entry goes in front; the oldest drops once sixty-four are held.
  function automatic void logPush(logic [7:0] b);
    elog.push_front(b);
    if (elog.size() > LOG_DEPTH) void'(elog.pop_back());
  endfunction
  // One register write, or one read whose data is compared in the cycle after the strobe.
  task automatic regAccess(bit wr, logic [3:0] a, logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= wr;
    regRd <= !wr;
    @(posedge sys_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(posedge sys_clk);
    if (!wr) check("regRdata", d, regRdata);
  endtask
  // Offers one request (flags are write timeout, broadcast, comm error, overrun), compares the reply, updates the model.
  task automatic run(logic [7:0] fc, logic [15:0] sub, logic [15:0] dat, logic [3:0] fl, logic [3:0] exc);
    logic [15:0] st;
    int n;
    bit rst;
    rst = (fc == FC_DIAG && sub == SUB_RESTART);
    excSel <= exc;
    wtoSel <= fl[3];
    req <= {fc, sub, dat, fl[2], fl[1], fl[0]};
    reqValid <= 1'b1;
    n = 0;
    do @(posedge sys_clk); while (reqReady !== 1'b1 && ++n < 100);
    check("request taken", 16'h0001, 16'(n < 100));
    reqValid <= 1'b0;
    req <= ~req;
    st = progBusy ? STATUS_BUSY : STATUS_IDLE;
    msgC++;
    logPush({1'b1, fl[2], lst, fl[0], 2'b00, fl[1], 1'b0});
    ovC += fl[0];
    expQ = {};
    if (!lst && !fl[2] && fc == FC_EVCNT) expQ = {fc, st[15:8], st[7:0], evC[15:8], evC[7:0]};
    if (!lst && !fl[2] && fc == FC_EVLOG) expQ = {fc, 8'(elog.size() + 6), st[15:8], st[7:0], evC[15:8], evC[7:0],
      msgC[15:8], msgC[7:0], elog};
    if (!lst && !fl[2] && fc == FC_DIAG && sub != SUB_LISTEN) expQ = {fc, sub[15:8], sub[7:0], dat[15:8], dat[7:0]};
    got = {};
    do begin
      @(posedge sys_clk);
      if (respValid === 1'b1 && respReady === 1'b1) begin
        got.push_back(respByte);
        check("respLast", 16'(got.size() == expQ.size()), 16'(respLast));
      end
    end while (reqReady !== 1'b1 && ++n < 300);
    check("request done", 16'h0001, 16'(n < 300));
    check("reply length", 16'(expQ.size()), 16'(got.size()));
    foreach (expQ[i]) if (i < got.size()) check("reply byte", expQ[i], got[i]);
    // In listen-only mode the block still logs a bare send event and counts the message, but not the event.
    if (lst && !rst) begin
      logPush(8'h60);
      return;
    end
    // A restart leaves listen-only mode before its send event is logged.
    if (rst) lst = 0;
    if (fc == FC_DIAG && sub == SUB_LISTEN) begin
      logPush(EV_LISTEN);
      lst = 1;
    end
    logPush({2'b01, lst, fl[3], exc == 4'h7, exc inside {[5:6]}, exc == 4'h4, exc inside {[1:3]}});
    if (exc == 4'h0 && fc != FC_EVCNT) evC++;
    if (fc == FC_DIAG && sub inside {SUB_RESTART, SUB_CLRCNT, SUB_CLROVR}) ovC = 0;
    if (fc == FC_DIAG && sub inside {SUB_RESTART, SUB_CLRCNT}) begin
      evC = 0;
      msgC = 0;
    end
    if (rst) begin
      lst = 0;
      if (dat == DATA_CLRLOG) elog = {};
      else if (stopErr) foreach (elog[i]) elog[i] = 8'h00;
      logPush(EV_RESTART);
    end
  endtask
  // Main sequence: reset, random traffic, then the hand-written corner cases.
  initial begin
    void'($urandom(50283));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    run(FC_EVCNT, 16'h0000, 16'h0000, 4'h0, 4'h0);
    for (int k = 0; k < 44; k++) begin
      progBusy <= 1'($urandom);
      case ($urandom_range(3))
        0: run(FC_DIAG, SUB_ECHO, 16'($urandom), 4'h0, 4'h0);
        1: run(8'h03, 16'($urandom), 16'($urandom), 4'($urandom), 4'($urandom_range(7)));
        2: run(FC_EVCNT, 16'h0000, 16'h0000, 4'h0, 4'h0);
        default: run(FC_EVLOG, 16'h0000, 16'h0000, 4'h0, 4'h0);
      endcase
    end
    run(8'h03, 16'h0000, 16'h0000, 4'h1, 4'h0);
    check("ovrFlag", 16'h0001, 16'(ovrFlag));
    check("ovrCount", 16'(ovC), ovrCount);
    run(FC_DIAG, SUB_CLROVR, 16'h0000, 4'h0, 4'h0);
    check("ovrFlag", 16'h0000, 16'(ovrFlag));
    regAccess(1, REG_EVCNT, 16'hFFFF);
    regAccess(0, REG_EVCNT, 16'(evC));
    regAccess(0, REG_MSGCNT, 16'(msgC));
    regAccess(0, REG_OVRCNT, 16'(ovC));
    regAccess(0, 4'hF, 16'h0000);
    regAccess(0, REG_STAT, {1'b0, 7'(elog.size()), 5'h00, progBusy, 1'b0, lst});
    run(FC_DIAG, SUB_RESTART, 16'h0000, 4'h0, 4'h0);
    run(FC_EVLOG, 16'h0000, 16'h0000, 4'h0, 4'h0);
    regAccess(1, REG_CTRL, 16'h0001);
    stopErr = 1;
    run(FC_DIAG, SUB_RESTART, 16'h0000, 4'h0, 4'h0);
    run(FC_DIAG, SUB_CLRCNT, 16'h0000, 4'h0, 4'h0);
    run(FC_EVLOG, 16'h0000, 16'h0000, 4'h0, 4'h0);
    run(FC_DIAG, SUB_LISTEN, 16'h0000, 4'h0, 4'h0);
    check("listenOnly", 16'h0001, 16'(listenOnly));
    run(FC_EVCNT, 16'h0000, 16'h0000, 4'h0, 4'h0);
    run(FC_DIAG, SUB_RESTART, DATA_CLRLOG, 4'h0, 4'h0);
    check("listenOnly", 16'h0000, 16'(listenOnly));
    run(FC_EVLOG, 16'h0000, 16'h0000, 4'h0, 4'h0);
    conclude();
  end
  // Watchdog far beyond the expected run length.
  initial begin
    #200000;
    check("watchdog", 16'h0000, 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire
